// File: verilog/eep_cfg.svh
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH

// system clock
`define CLK_PERIOD_NS 8

// strobe low time, covers glitch filter and read access
`define STROBE_NS 150
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// quiet time that closes a page load (least time, rounded up)
`define PAGE_TO_US 200
`define PAGE_TO_CYC ((`PAGE_TO_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// device lock-out after a refused write (least time, rounded up)
`define LOCK_US 300
`define LOCK_CYC ((`LOCK_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// polls allowed before giving up
`define POLL_MAX 4096

// register offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0c
`define REG_CFG 8'h10

// status bit positions
`define ST_BUSY 0
`define ST_PAGE 1
`define ST_PROT 2
`define ST_IDM 3
`define ST_ERR_POLL 4
`define ST_ERR_PAGE 5
`define ST_REFUSED 6
`define ST_RBYTE_LO 8

// reset value of the protect-prefix enable
`define CFG_USE_PROT_RST 1'b1

// command addresses and codes
`define ADDR_CMD1 16'h5555
`define ADDR_CMD2 16'h2aaa
`define DATA_UNLOCK1 8'haa
`define DATA_UNLOCK2 8'h55
`define FN_PROT_LOAD 8'ha0
`define FN_SIX_BYTE 8'h80
`define FN_ID_ENTRY 8'h90
`define FN_ID_EXIT 8'hf0
`define FN_PROT_OFF 8'h20
`define FN_ERASE 8'h10

// step indices of a command sequence
`define IDX_FN3 3'h2
`define IDX_DATA 3'h3
`define IDX_UNLOCK2B 3'h4
`define IDX_FN6 3'h5
`define IDX_UNLOCK2A 3'h1

// page select bits
`define PAGE_HI 15
`define PAGE_LO 7

`endif

// File: verilog/eep_pkg.sv
package eep_pkg;

  // one pin-level bus cycle request
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } pin_req_t;

  // device-facing pins, driven side
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [15:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
  } pins_t;

  typedef enum logic [2:0] {PC_IDLE, PC_SETUP, PC_STROBE, PC_HOLD, PC_SAMPLE} pin_phase_t;

  typedef enum logic [2:0] {OP_NONE, OP_READ, OP_LOAD, OP_PROT_OFF, OP_ERASE, OP_ID_ENTRY, OP_ID_EXIT} host_op_t;

  typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_READ, ST_PAGE, ST_POLL, ST_LOCK} host_state_t;

endpackage : eep_pkg

// File: verilog/eep_pin_cycle.sv
`timescale 1ns/1ps
`include "eep_cfg.svh"

module eep_pin_cycle
  import eep_pkg::*;
#(
  parameter int STROBE_CYC = `STROBE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input pin_req_t i_req,
  input wire logic [7:0] i_dq,
  output logic o_done,
  output logic [7:0] o_rdata,
  output pins_t o_pins
);

  typedef struct packed {
    pin_phase_t phase;
    logic [7:0] cnt;
    logic wr;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] rdata;
    logic done;
    pins_t pins;
  } pc_state_t;

  pc_state_t s_r;
  pc_state_t s_nxt;

  // strobe must outlast the glitch filter and fit the counter
  if (STROBE_CYC < 9 || STROBE_CYC > 255) begin : g_chk
    $error("STROBE_CYC out of range");
  end

  // one pin cycle: setup, strobe, hold or sample
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.sync1 = i_dq;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    case (s_r.phase)
      PC_IDLE: begin
        if (i_start) begin
          s_nxt.wr = i_req.wr;
          s_nxt.pins.addr = i_req.addr;
          s_nxt.pins.dq_o = i_req.data;
          s_nxt.pins.dq_oe = i_req.wr;
          s_nxt.phase = PC_SETUP;
        end
      end
      PC_SETUP: begin
        s_nxt.pins.ce_n = 1'b0;
        s_nxt.cnt = 8'h00;
        if (s_r.wr) begin
          s_nxt.pins.we_n = 1'b0;
        end else begin
          s_nxt.pins.oe_n = 1'b0;
        end
        s_nxt.phase = PC_STROBE;
      end
      PC_STROBE: begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        if (s_r.cnt == 8'(STROBE_CYC - 1)) begin
          if (s_r.wr) begin
            s_nxt.pins.we_n = 1'b1;
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.phase = PC_HOLD;
          end else begin
            s_nxt.phase = PC_SAMPLE;
          end
        end
      end
      PC_HOLD: begin
        // data held one cycle past the rising strobe
        s_nxt.pins.dq_oe = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.phase = PC_IDLE;
      end
      PC_SAMPLE: begin
        if (s_r.sync2 == s_r.sync3) begin
          s_nxt.rdata = s_r.sync3;
          s_nxt.pins.oe_n = 1'b1;
          s_nxt.pins.ce_n = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.phase = PC_IDLE;
        end
      end
      default: s_nxt.phase = PC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.pins.ce_n <= 1'b1;
      s_r.pins.oe_n <= 1'b1;
      s_r.pins.we_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_done = s_r.done;
  assign o_rdata = s_r.rdata;
  assign o_pins = s_r.pins;

  // write strobe never overlaps output gate
  property p_inhibit;
    @(posedge i_clk) disable iff (i_rst) !o_pins.we_n |-> o_pins.oe_n && !o_pins.ce_n;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("write strobe with output gate low");

  // host drives data only while device outputs are off
  property p_dq_float;
    @(posedge i_clk) disable iff (i_rst) o_pins.dq_oe |-> o_pins.oe_n;
  endproperty
  a_dq_float: assert property (p_dq_float) else $error("bus fight on data pins");

  // strobe pulse far above glitch width
  property p_pulse;
    @(posedge i_clk) disable iff (i_rst) $fell(o_pins.we_n) |-> !o_pins.we_n [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("write strobe too short");

  // address and data unchanged across the strobe rise, data still driven after it
  sequence s_strobe_end;
    !o_pins.we_n ##1 o_pins.we_n;
  endsequence
  property p_latch;
    @(posedge i_clk) disable iff (i_rst) s_strobe_end |-> o_pins.dq_oe && $stable(o_pins.dq_o) && $stable(o_pins.addr);
  endproperty
  a_latch: assert property (p_latch) else $error("data not held past strobe rise");

endmodule : eep_pin_cycle

// File: verilog/eep_host.sv
// Operation
// - protected writes need three-byte unlock prefix
// - six-byte sequence alone clears protection
// - host keeps protection on, uses prefix
// - identification mode ends on exit command
// - page ends after load timeout quiet
// - address on later fall, data earlier rise
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "eep_cfg.svh"

module eep_host
  import eep_pkg::*;
#(
  parameter int PAGE_TO_CYC = `PAGE_TO_CYC,
  parameter int LOCK_CYC = `LOCK_CYC,
  parameter int POLL_MAX = `POLL_MAX
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [15:0] o_addr,
  output logic [7:0] o_dq_o,
  output logic o_dq_oe,
  input wire logic [7:0] i_dq_i
);

  typedef struct packed {
    host_state_t st;
    host_op_t op;
    logic [2:0] idx;
    logic [2:0] last_idx;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [15:0] page_addr;
    logic prefixed;
    logic use_prot;
    logic prot;
    logic id_mode;
    logic err_poll;
    logic err_page;
    logic refused;
    logic [7:0] rbyte;
    logic prev6;
    logic first_poll;
    logic [19:0] cnt;
    logic [15:0] pcnt;
    logic start;
    pin_req_t req;
    logic [31:0] rdata;
  } host_s_t;

  host_s_t s_r;
  host_s_t s_nxt;
  logic pc_done;
  logic [7:0] pc_rdata;
  pins_t pins;
  logic cmd;
  host_op_t cmd_op;

  if (PAGE_TO_CYC < 1 || PAGE_TO_CYC >= (1 << 20) || LOCK_CYC < 1 || LOCK_CYC >= (1 << 20)
      || POLL_MAX < 2 || POLL_MAX >= (1 << 16)) begin : g_chk
    $error("timing parameter out of range");
  end

  // command step table: unlock pair, function byte, then load data or a repeated unlock pair and a second function byte
  function automatic pin_req_t seq_step(input host_op_t op, input logic [2:0] idx,
                                        input logic [15:0] a, input logic [7:0] d);
    pin_req_t r;
    r.wr = 1'b1;
    r.addr = `ADDR_CMD1;
    r.data = `DATA_UNLOCK1;
    if (idx == `IDX_UNLOCK2A || idx == `IDX_UNLOCK2B) begin
      r.addr = `ADDR_CMD2;
      r.data = `DATA_UNLOCK2;
    end else if (idx == `IDX_FN3) begin
      case (op)
        OP_LOAD: r.data = `FN_PROT_LOAD;
        OP_ID_ENTRY: r.data = `FN_ID_ENTRY;
        OP_ID_EXIT: r.data = `FN_ID_EXIT;
        default: r.data = `FN_SIX_BYTE;
      endcase
    end else if (idx == `IDX_DATA && op == OP_LOAD) begin
      r.addr = a;
      r.data = d;
    end else if (idx == `IDX_FN6) begin
      r.data = (op == OP_ERASE) ? `FN_ERASE : `FN_PROT_OFF;
    end
    return r;
  endfunction : seq_step

  assign cmd = i_wr && (i_addr == `REG_CTRL);
  assign cmd_op = host_op_t'(i_wdata[2:0]);

  // register writes, command sequencer and polling
  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.rdata = 32'h0000_0000;
    if (i_wr) begin
      if (i_addr == `REG_ADDR) begin
        s_nxt.addr = i_wdata[15:0];
      end else if (i_addr == `REG_WDATA) begin
        s_nxt.wdata = i_wdata[7:0];
      end else if (i_addr == `REG_CFG) begin
        s_nxt.use_prot = i_wdata[0];
      end else if (i_addr == `REG_STATUS) begin
        if (i_wdata[`ST_ERR_POLL]) s_nxt.err_poll = 1'b0;
        if (i_wdata[`ST_ERR_PAGE]) s_nxt.err_page = 1'b0;
        if (i_wdata[`ST_REFUSED]) s_nxt.refused = 1'b0;
      end
    end
    case (s_r.st)
      ST_IDLE: begin
        if (cmd) begin
          s_nxt.op = cmd_op;
          s_nxt.idx = 3'h0;
          s_nxt.start = 1'b1;
          s_nxt.st = ST_SEQ;
          s_nxt.last_idx = `IDX_FN3;
          case (cmd_op)
            OP_READ: begin
              // in identification mode addr 0 and 1 give the codes
              s_nxt.req = '{wr: 1'b0, addr: s_r.addr, data: 8'h00};
              s_nxt.st = ST_READ;
            end
            OP_LOAD: begin
              s_nxt.page_addr = s_r.addr;
              s_nxt.prefixed = s_r.use_prot;
              s_nxt.idx = s_r.use_prot ? 3'h0 : `IDX_DATA;
              s_nxt.last_idx = `IDX_DATA;
              s_nxt.req = seq_step(OP_LOAD, s_nxt.idx, s_r.addr, s_r.wdata);
            end
            OP_PROT_OFF, OP_ERASE: begin
              s_nxt.last_idx = `IDX_FN6;
              s_nxt.req = seq_step(cmd_op, 3'h0, s_r.addr, s_r.wdata);
            end
            OP_ID_ENTRY, OP_ID_EXIT: begin
              s_nxt.req = seq_step(cmd_op, 3'h0, s_r.addr, s_r.wdata);
            end
            default: begin
              s_nxt.start = 1'b0;
              s_nxt.st = ST_IDLE;
              s_nxt.refused = 1'b1;
            end
          endcase
        end
      end
      ST_SEQ: begin
        if (pc_done) begin
          if (s_r.idx == s_r.last_idx) begin
            s_nxt.st = ST_IDLE;
            s_nxt.cnt = 20'h00000;
            s_nxt.first_poll = 1'b1;
            s_nxt.pcnt = 16'h0000;
            case (s_r.op)
              OP_LOAD: begin
                s_nxt.st = ST_PAGE;
                if (s_r.prefixed) s_nxt.prot = 1'b1;
              end
              OP_PROT_OFF: begin
                s_nxt.prot = 1'b0;
                s_nxt.st = ST_POLL;
              end
              OP_ERASE: s_nxt.st = ST_POLL;
              OP_ID_ENTRY: s_nxt.id_mode = 1'b1;
              OP_ID_EXIT: s_nxt.id_mode = 1'b0;
              default: s_nxt.st = ST_IDLE;
            endcase
            if (s_nxt.st == ST_POLL) begin
              s_nxt.start = 1'b1;
              s_nxt.req = '{wr: 1'b0, addr: s_r.addr, data: 8'h00};
            end
          end else begin
            s_nxt.idx = s_r.idx + 3'h1;
            s_nxt.start = 1'b1;
            s_nxt.req = seq_step(s_r.op, s_nxt.idx, s_r.addr, s_r.wdata);
          end
        end
      end
      ST_READ: begin
        if (pc_done) begin
          s_nxt.rbyte = pc_rdata;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_PAGE: begin
        s_nxt.cnt = s_r.cnt + 20'h00001;
        if (cmd && cmd_op == OP_LOAD) begin
          if (s_r.addr[`PAGE_HI:`PAGE_LO] != s_r.page_addr[`PAGE_HI:`PAGE_LO]) begin
            s_nxt.err_page = 1'b1;
          end else begin
            s_nxt.idx = `IDX_DATA;
            s_nxt.start = 1'b1;
            s_nxt.req = seq_step(OP_LOAD, `IDX_DATA, s_r.addr, s_r.wdata);
            s_nxt.st = ST_SEQ;
          end
        end else if (cmd) begin
          s_nxt.refused = 1'b1;
        end else if (s_r.cnt == 20'(PAGE_TO_CYC - 1)) begin
          s_nxt.cnt = 20'h00000;
          if (s_r.prot && !s_r.prefixed) begin
            s_nxt.refused = 1'b1;
            s_nxt.st = ST_LOCK;
          end else begin
            s_nxt.st = ST_POLL;
            s_nxt.start = 1'b1;
            s_nxt.req = '{wr: 1'b0, addr: s_r.addr, data: 8'h00};
          end
        end
      end
      ST_POLL: begin
        if (pc_done) begin
          s_nxt.rbyte = pc_rdata;
          if (!s_r.first_poll && pc_rdata[6] == s_r.prev6) begin
            s_nxt.st = ST_IDLE;
          end else if (s_r.pcnt == 16'(POLL_MAX - 1)) begin
            s_nxt.err_poll = 1'b1;
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.prev6 = pc_rdata[6];
            s_nxt.first_poll = 1'b0;
            s_nxt.pcnt = s_r.pcnt + 16'h0001;
            s_nxt.start = 1'b1;
          end
        end
      end
      ST_LOCK: begin
        s_nxt.cnt = s_r.cnt + 20'h00001;
        if (s_r.cnt == 20'(LOCK_CYC - 1)) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // commands while the device is busy are turned away
    if (cmd && s_r.st != ST_IDLE && s_r.st != ST_PAGE) begin
      s_nxt.refused = 1'b1;
    end
    if (i_rd) begin
      if (i_addr == `REG_CTRL) begin
        s_nxt.rdata = {29'h0000_0000, s_r.op};
      end else if (i_addr == `REG_ADDR) begin
        s_nxt.rdata = {16'h0000, s_r.addr};
      end else if (i_addr == `REG_WDATA) begin
        s_nxt.rdata = {24'h00_0000, s_r.wdata};
      end else if (i_addr == `REG_STATUS) begin
        s_nxt.rdata[`ST_BUSY] = s_r.st != ST_IDLE && s_r.st != ST_PAGE;
        s_nxt.rdata[`ST_PAGE] = s_r.st == ST_PAGE;
        s_nxt.rdata[`ST_PROT] = s_r.prot;
        s_nxt.rdata[`ST_IDM] = s_r.id_mode;
        s_nxt.rdata[`ST_ERR_POLL] = s_r.err_poll;
        s_nxt.rdata[`ST_ERR_PAGE] = s_r.err_page;
        s_nxt.rdata[`ST_REFUSED] = s_r.refused;
        s_nxt.rdata[`ST_RBYTE_LO +: 8] = s_r.rbyte;
      end else if (i_addr == `REG_CFG) begin
        s_nxt.rdata = {31'h0000_0000, s_r.use_prot};
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.use_prot <= `CFG_USE_PROT_RST;
      s_r.prot <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  eep_pin_cycle #(
    .STROBE_CYC(`STROBE_CYC)
  ) u_pin (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(s_r.start),
    .i_req(s_r.req),
    .i_dq(i_dq_i),
    .o_done(pc_done),
    .o_rdata(pc_rdata),
    .o_pins(pins)
  );

  assign o_rdata = s_r.rdata;
  assign o_ce_n = pins.ce_n;
  assign o_oe_n = pins.oe_n;
  assign o_we_n = pins.we_n;
  assign o_addr = pins.addr;
  assign o_dq_o = pins.dq_o;
  assign o_dq_oe = pins.dq_oe;

  // a command sequence started at step 0 opens with the first unlock byte
  property p_unlock_first;
    @(posedge i_clk) disable iff (i_rst)
      s_r.start && s_r.st == ST_SEQ && s_r.idx == 3'h0 |-> s_r.req.addr == `ADDR_CMD1 && s_r.req.data == `DATA_UNLOCK1;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("sequence not opened by unlock");

  // busy command sets the refused flag
  property p_busy_refuse;
    @(posedge i_clk) disable iff (i_rst)
      cmd && (s_r.st == ST_SEQ || s_r.st == ST_POLL || s_r.st == ST_READ) |=> s_r.refused;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy command not refused");

  // polling after a page load starts only after the full quiet time
  sequence s_page_to_poll;
    s_r.st == ST_PAGE ##1 s_r.st == ST_POLL;
  endsequence
  property p_page_quiet;
    @(posedge i_clk) disable iff (i_rst) s_page_to_poll |-> $past(s_r.cnt) == 20'(PAGE_TO_CYC - 1);
  endproperty
  a_page_quiet: assert property (p_page_quiet) else $error("page closed early");

  // protection rises only after a prefixed load
  property p_prot_set;
    @(posedge i_clk) disable iff (i_rst) $rose(s_r.prot) |-> $past(s_r.op) == OP_LOAD && $past(s_r.prefixed);
  endproperty
  a_prot_set: assert property (p_prot_set) else $error("protection set without prefix");

  // protection falls only at end of six-byte sequence
  property p_prot_clr;
    @(posedge i_clk) disable iff (i_rst) $fell(s_r.prot) |-> $past(s_r.op) == OP_PROT_OFF && $past(s_r.idx) == `IDX_FN6;
  endproperty
  a_prot_clr: assert property (p_prot_clr) else $error("protection cleared wrongly");

  // identification mode left only by exit command
  property p_id_exit;
    @(posedge i_clk) disable iff (i_rst) $fell(s_r.id_mode) |-> $past(s_r.op) == OP_ID_EXIT;
  endproperty
  a_id_exit: assert property (p_id_exit) else $error("identification mode left without exit");

endmodule : eep_host

// File: bench/eep_dev_model.sv
`timescale 1ns/1ps
module eep_dev_model #(
  parameter logic [7:0] MAKER = 8'h3c, // arbitrary value
  parameter logic [7:0] PART = 8'hc3, // arbitrary value
  parameter int PAGE_TO = 45,
  parameter int BUSY = 100,
  parameter int LOCK = 30
) (
  input wire logic i_clk,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_dq_oe,
  output logic [7:0] o_wire,
  output logic o_clash
);
  logic [7:0] mem [0:65535];
  logic [7:0] pbuf [0:127];
  logic [127:0] ld_r;
  logic [8:0] pg_r;
  logic [15:0] a_cap;
  logic [7:0] last_r, wire_r, dev_val;
  logic prot_r, pfx_r, id_r, tog_r, rd_p, lock_seen;
  int cs, idle, busy, lockc, wl, reads;
  // drives only when selected, gated on, not writing, not locked out
  wire dev_oe = !i_ce_n && !i_oe_n && i_we_n && lockc == 0;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
    {ld_r, pg_r, a_cap, last_r, wire_r, pfx_r, id_r, tog_r, rd_p, lock_seen, o_clash} = '0;
    prot_r = 1'b0;
    {cs, idle, busy, lockc, wl, reads} = '0;
  end
  // read value: id codes, status while busy, else array
  always_comb begin
    if (id_r) dev_val = i_addr[0] ? PART : MAKER;
    else if (busy > 0) dev_val = {~last_r[7], tog_r, 6'h00};
    else dev_val = mem[i_addr];
  end
  // released wire shows the inverse of its last level
  assign o_wire = i_dq_oe ? i_dq : dev_oe ? dev_val : ~wire_r;
  // one byte load: command steps or page data
  task automatic take(input logic [15:0] a, input logic [7:0] d);
    if (busy > 0 || lockc > 0) return;
    if (cs == 0 && a == 16'h5555 && d == 8'haa) cs = 1;
    else if (cs == 1 || cs == 4) cs = (a == 16'h2aaa && d == 8'h55) ? cs + 1 : 0;
    else if (cs == 3) cs = (a == 16'h5555 && d == 8'haa) ? 4 : 0;
    else if (cs == 2 && a == 16'h5555) begin
      cs = 0;
      if (d == 8'ha0) {prot_r, pfx_r} = 2'b11;
      if (d == 8'h90) id_r = 1'b1;
      if (d == 8'hf0) id_r = 1'b0;
      if (d == 8'h80) cs = 3;
    end else if (cs == 5 && a == 16'h5555) begin
      cs = 0;
      if (d == 8'h20) prot_r = 1'b0;
      if (d == 8'h10) for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
      if (d == 8'h20 || d == 8'h10) {busy, tog_r} = {BUSY, 1'b1};
    end else begin
      cs = 0;
      pbuf[a[6:0]] = d;
      ld_r[a[6:0]] = 1'b1;
      pg_r = a[15:7];
      last_r = d;
      idle = PAGE_TO;
    end
  endtask
  // mid-cycle sampling keeps clear of the host's edges
  always @(negedge i_clk) begin
    wire_r <= o_wire;
    if (i_dq_oe && dev_oe) o_clash = 1'b1;
    if (!i_ce_n && !i_we_n && i_oe_n) begin
      if (wl == 0) a_cap = i_addr;
      wl++;
    end else if (wl > 0) begin
      if (wl * 8 > 5) take(a_cap, i_dq);
      wl = 0;
    end
    if (rd_p && !dev_oe && busy > 0) begin
      tog_r = ~tog_r;
      reads++;
    end
    rd_p = dev_oe;
    if (busy > 0) busy--;
    if (lockc > 0) lockc--;
    if (idle > 0) begin
      idle--;
      if (idle == 0 && prot_r && !pfx_r) {lockc, lock_seen} = {LOCK, 1'b1};
      else if (idle == 0) begin
        for (int i = 0; i < 128; i++) mem[{pg_r, i[6:0]}] = ld_r[i] ? pbuf[i] : 8'hff;
        {busy, tog_r} = {BUSY, 1'b1};
      end
      if (idle == 0) {ld_r, pfx_r} = '0;
    end
  end
endmodule : eep_dev_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "eep_cfg.svh"
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata, rv;
  logic [7:0] dq, dq_o, b;
  logic [15:0] a;
  logic ce_n, oe_n, we_n, dq_oe, clash;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #4 i_clk = ~i_clk;
  eep_host #(.PAGE_TO_CYC(50), .LOCK_CYC(50), .POLL_MAX(16)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(ce_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(a), .o_dq_o(dq_o), .o_dq_oe(dq_oe), .i_dq_i(dq));
  eep_dev_model dev_u (.i_clk(i_clk), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(a),
    .i_dq(dq_o), .i_dq_oe(dq_oe), .o_wire(dq), .o_clash(clash));
  task automatic results();
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // poll status until neither busy nor page open
  task automatic idle();
    logic [31:0] s;
    repeat (2) @(posedge i_clk);
    for (int i = 0; i < 600; i++) begin
      rd(`REG_STATUS, s);
      if (s[1:0] === 2'b00) return;
    end
    chk(s, 32'h0);
  endtask : idle
  task automatic cmd(input logic [31:0] op);
    wr(`REG_CTRL, op);
    idle();
  endtask : cmd
  task automatic dread(input logic [15:0] ad, output logic [7:0] v);
    logic [31:0] s;
    wr(`REG_ADDR, {16'h0, ad});
    cmd(32'h1);
    rd(`REG_STATUS, s);
    v = s[15:8];
  endtask : dread
  task automatic load(input logic [15:0] ad, input logic [7:0] d);
    wr(`REG_ADDR, {16'h0, ad});
    wr(`REG_WDATA, {24'h0, d});
    cmd(32'h2);
  endtask : load
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`REG_STATUS, rv);
    chk(rv, 32'h0);
    rd(`REG_CFG, rv);
    chk(rv, 32'h1);
    rd(8'h20, rv);
    chk(rv, 32'h0);
    // opcode zero is turned away
    wr(`REG_CTRL, 32'h0);
    rd(`REG_STATUS, rv);
    chk(rv, 32'h40);
    wr(`REG_STATUS, 32'h40);
    cmd(32'h5);
    rd(`REG_STATUS, rv);
    chk(rv & 32'h8, 32'h8);
    dread(16'h0000, b);
    chk({24'h0, b}, {24'h0, dev_u.MAKER});
    dread(16'h0001, b);
    chk({24'h0, b}, {24'h0, dev_u.PART});
    cmd(32'h6);
    dread(16'h0000, b);
    chk({24'h0, b}, 32'hff);
    // prefixed load, then a command refused while busy
    wr(`REG_ADDR, 32'h0105);
    wr(`REG_WDATA, 32'h5a);
    wr(`REG_CTRL, 32'h2);
    wr(`REG_CTRL, 32'h1);
    idle();
    rd(`REG_STATUS, rv);
    chk(rv & 32'h74, 32'h44);
    chk({31'h0, dev_u.prot_r}, 32'h1);
    chk({31'h0, dev_u.reads >= 2}, 32'h1);
    wr(`REG_STATUS, 32'h40);
    rd(`REG_STATUS, rv);
    chk(rv & 32'h40, 32'h0);
    dread(16'h0105, b);
    chk({24'h0, b}, 32'h5a);
    dread(16'h0104, b);
    chk({24'h0, b}, 32'hff);
    // unprefixed load while protected is dropped
    wr(`REG_CFG, 32'h0);
    load(16'h0200, 8'h11);
    rd(`REG_STATUS, rv);
    chk(rv & 32'h44, 32'h44);
    chk({31'h0, dev_u.lock_seen}, 32'h1);
    dread(16'h0200, b);
    chk({24'h0, b}, 32'hff);
    wr(`REG_STATUS, 32'h40);
    cmd(32'h3);
    rd(`REG_STATUS, rv);
    chk(rv & 32'h74, 32'h0);
    chk({31'h0, dev_u.prot_r}, 32'h0);
    // two bytes in one page, then a foreign page and a read while open
    wr(`REG_ADDR, 32'h0300);
    wr(`REG_WDATA, 32'h22);
    wr(`REG_CTRL, 32'h2);
    repeat (30) @(posedge i_clk);
    wr(`REG_ADDR, 32'h0301);
    wr(`REG_WDATA, 32'h33);
    wr(`REG_CTRL, 32'h2);
    repeat (30) @(posedge i_clk);
    wr(`REG_ADDR, 32'h0400);
    wr(`REG_CTRL, 32'h2);
    wr(`REG_CTRL, 32'h1);
    idle();
    rd(`REG_STATUS, rv);
    chk(rv & 32'h60, 32'h60);
    dread(16'h0300, b);
    chk({24'h0, b}, 32'h22);
    dread(16'h0301, b);
    chk({24'h0, b}, 32'h33);
    wr(`REG_CFG, 32'h1);
    cmd(32'h4);
    dread(16'h0105, b);
    chk({24'h0, b}, 32'hff);
    dread(16'h0300, b);
    chk({24'h0, b}, 32'hff);
    chk({31'h0, clash}, 32'h0);
    results();
  end
endmodule : tb_top
